// [logic/cnd_node_services.sv]
`default_nettype none
module cnd_node_services #(
  parameter int unsigned TICK_CYCLES = cnd_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // drive status
  input wire logic [7:0] alarm_status_param_in,
  input wire logic [4:0] digital_inputs_in,
  input wire logic drive_enable_in,
  input wire logic [9:0] aux_analog_in,
  // can protocol side
  input wire cnd_pkg::cnd_sdo_req_t sdo_req_in,
  output cnd_pkg::cnd_sdo_rsp_t sdo_rsp_out,
  input wire logic sdo_busy_in,
  output logic sdo_timeout_out,
  input wire logic nmt_valid_in,
  input wire logic [7:0] nmt_cmd_in,
  input wire logic [6:0] nmt_node_in,
  input wire logic guard_rx_in,
  input wire logic bus_off_in,
  input wire logic sync_missing_in,
  input wire logic sync_in,
  input wire logic rtr_valid_in,
  input wire logic [1:0] rtr_chan_in,
  output logic rtr_accept_out,
  output logic pdo12_service_out,
  output logic pdo4_tx_out,
  output logic hb_send_out,
  output cnd_pkg::cnd_nmt_t nmt_state_out,
  // emergency frame to controller
  output logic emcy_valid_out,
  input wire logic emcy_ready_in,
  output cnd_pkg::cnd_frame_t emcy_frame_out
);
  function automatic logic [15:0] alarm_code(input logic [7:0] a);
    unique case (a)
      8'h01: alarm_code = 16'h3210;
      8'h02: alarm_code = 16'h3220;
      8'h03: alarm_code = 16'h2340;
      8'h04: alarm_code = 16'h7310;
      8'h05: alarm_code = 16'hFF07;
      8'h06: alarm_code = 16'h4310;
      8'h07: alarm_code = 16'hFF00;
      8'h08: alarm_code = 16'hFF01;
      8'h0A, 8'h0B: alarm_code = 16'h6310;
      8'h0F: alarm_code = 16'h6320;
      8'h10: alarm_code = 16'hFF03;
      8'h11: alarm_code = 16'hFF08;
      8'h14: alarm_code = 16'hFF0A;
      8'h15: alarm_code = 16'h5112;
      8'h16: alarm_code = 16'h4110;
      8'h17: alarm_code = 16'hFF0C;
      8'h18: alarm_code = 16'hFF0D;
      8'h19: alarm_code = 16'hFF0E;
      8'h1A: alarm_code = 16'hFF0F;
      8'h1C: alarm_code = 16'h7320;
      default: alarm_code = {8'hFF, a};
    endcase
  endfunction

  function automatic cnd_pkg::cnd_nmt_t err_state(input logic [1:0] b,
                                                  input cnd_pkg::cnd_nmt_t s);
    unique case (b)
      2'd0: err_state = cnd_pkg::CND_PREOP;
      2'd2: err_state = cnd_pkg::CND_STOP;
      default: err_state = s;
    endcase
  endfunction

  // register file
  logic [2:0] ctrl_reg;
  logic [6:0] node_reg;
  logic [31:0] pop_reg;
  logic [15:0] sdo_tmo_reg, hb_reg, guard_reg;
  logic [7:0] life_reg;
  logic [1:0] errb_reg;
  logic map_ok_reg, map_err_reg;
  logic [15:0] inw_reg;

  // axi handshake state
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire [7:0] wa = aw_take ? s_axi_awaddr_in : aw_addr_reg;
  wire [31:0] wd = w_take ? s_axi_wdata_in : w_data_reg;
  wire [3:0] ws = w_take ? s_axi_wstrb_in : w_strb_reg;
  wire wr_go = (aw_take || aw_got_reg) && (w_take || w_got_reg) && !s_axi_bvalid_out;
  wire wr_ctrl = wr_go && wa == cnd_pkg::A_CTRL && ws[0];
  wire wr_map = wr_go && wa == cnd_pkg::A_MAP && (&ws);
  wire wr_hit = wa <= cnd_pkg::A_INW && wa[1:0] == 2'b00;

  // map entry: [31:16] object index, bit 1 pdo4, bit 0 tx side, [15:8] bit length
  wire map_p4 = wd[1];
  wire map_tx = wd[0];
  wire [15:0] map_idx = wd[31:16];
  wire p4_rx_ok = map_idx == 16'h6040 || map_idx == 16'h60C1;
  wire p4_tx_ok = map_idx == 16'h6041 || map_idx == 16'h6063 ||
                  map_idx == 16'h6064 || map_idx == 16'h2060;
  wire len_ok = wd[15:8] == 8'd16 || wd[15:8] == 8'd32;
  wire map_good = len_ok && (!map_p4 || (map_tx ? p4_tx_ok : p4_rx_ok));

  // ticks
  logic [31:0] tick_cnt_reg;
  logic tick_half_reg;
  wire tick = tick_cnt_reg == TICK_CYCLES - 1;

  // emergency queue
  cnd_pkg::cnd_emcy_t q_reg [cnd_pkg::QDEPTH];
  logic [1:0] q_rd_reg, q_wr_reg;
  logic [2:0] q_cnt_reg;
  logic [7:0] alarm_prev_reg;
  logic pop_pend_reg;
  wire q_full = q_cnt_reg == 3'(cnd_pkg::QDEPTH);
  wire alarm_chg = alarm_status_param_in != alarm_prev_reg;
  wire alarm_push = alarm_chg && !ctrl_reg[cnd_pkg::B_SUPP] && !q_full;
  wire pop_push = ctrl_reg[cnd_pkg::B_POPUP] && !pop_pend_reg && !alarm_push && !q_full;
  wire q_push = alarm_push || pop_push;
  logic emcy_pop_reg;
  wire load = (!emcy_valid_out || emcy_ready_in) && q_cnt_reg != 3'd0;
  wire sent = emcy_valid_out && emcy_ready_in;
  wire pop_done = sent && emcy_pop_reg;
  cnd_pkg::cnd_emcy_t new_e;
  always_comb begin
    new_e.popup = !alarm_push;
    new_e.code = alarm_push ? (alarm_status_param_in == 8'h00 ? 16'h0000
                               : alarm_code(alarm_status_param_in))
                            : cnd_pkg::POPUP_CODE;
    new_e.data = alarm_push ? {24'h0, alarm_status_param_in} : pop_reg;
  end
  cnd_pkg::cnd_emcy_t head;
  assign head = q_reg[q_rd_reg];

  // guarding and heartbeat
  wire hb_on = hb_reg != 16'h0000;
  wire guard_on = !hb_on && guard_reg != 16'h0000 && life_reg != 8'h00;
  wire [23:0] life_lim = 24'(guard_reg) * 24'(life_reg);
  logic [23:0] life_cnt_reg;
  logic [15:0] hb_cnt_reg, sdo_cnt_reg;
  logic bus_off_prev_reg, sync_prev_reg;
  wire guard_miss = guard_on && tick && life_cnt_reg >= life_lim;
  wire bus_off_evt = bus_off_in && !bus_off_prev_reg;
  wire sync_evt = sync_missing_in && !sync_prev_reg && ctrl_reg[cnd_pkg::B_SYNCCHK];
  wire guard_evt = guard_miss || bus_off_evt || sync_evt;

  // nmt
  logic nmt_pend_reg;
  logic [7:0] nmt_cs_reg;
  wire nmt_mine = nmt_valid_in && (nmt_node_in == 7'h00 || nmt_node_in == node_reg);
  cnd_pkg::cnd_nmt_t nmt_next;
  always_comb begin
    nmt_next = nmt_state_out;
    if (nmt_state_out == cnd_pkg::CND_BOOT && tick) begin
      nmt_next = cnd_pkg::CND_PREOP;
    end else if (tick && nmt_pend_reg) begin
      unique case (nmt_cs_reg)
        cnd_pkg::NMT_START: nmt_next = cnd_pkg::CND_OPER;
        cnd_pkg::NMT_STOP: nmt_next = cnd_pkg::CND_STOP;
        cnd_pkg::NMT_PREOP: nmt_next = cnd_pkg::CND_PREOP;
        cnd_pkg::NMT_RSTN, cnd_pkg::NMT_RSTC: nmt_next = cnd_pkg::CND_BOOT;
        default: nmt_next = nmt_state_out;
      endcase
    end
    if (guard_evt) begin
      nmt_next = err_state(errb_reg, nmt_next);
    end
  end
  wire oper = nmt_state_out == cnd_pkg::CND_OPER;

  // parameter store and sdo decode
  logic [15:0] par_reg [cnd_pkg::PAR_COUNT];
  wire [15:0] s_idx = sdo_req_in.index;
  wire s_hi = s_idx[0];
  wire s_rw = s_idx[15:1] == 15'h1000;
  wire s_set = s_idx[15:1] == 15'h1001;
  wire s_clr = s_idx[15:1] == 15'h1002;
  wire s_par = s_rw || s_set || s_clr;
  wire [9:0] s_base = s_hi ? {1'b0, cnd_pkg::HI_BASE} : 10'h000;
  wire [9:0] s_pn = s_base + {2'b00, sdo_req_in.sub} - 10'd1;
  wire [9:0] s_pn1 = s_pn + 10'd1;
  wire [9:0] s_cnt = s_hi ? 10'(cnd_pkg::PAR_COUNT) - {1'b0, cnd_pkg::HI_BASE}
                          : {1'b0, cnd_pkg::HI_BASE};
  wire s_sub0 = sdo_req_in.sub == 8'h00;
  wire s_inr = !s_sub0 && s_pn < 10'(cnd_pkg::PAR_COUNT);
  wire s_nx = s_pn1 < 10'(cnd_pkg::PAR_COUNT);
  wire s_ok = s_par && (s_inr || (s_sub0 && !sdo_req_in.write));
  wire s_wr = sdo_req_in.valid && sdo_req_in.write && s_ok;
  wire [15:0] p_lo = s_inr ? par_reg[s_pn[8:0]] : 16'h0000;
  wire [15:0] p_hi = s_inr && s_nx ? par_reg[s_pn1[8:0]] : 16'h0000;
  wire [15:0] w_lo = s_set ? (p_lo | sdo_req_in.data[15:0])
                   : s_clr ? (p_lo & ~sdo_req_in.data[15:0])
                   : sdo_req_in.data[15:0];

  // register read mux
  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr_in)
      cnd_pkg::A_CTRL: rd_mux = {29'h0, ctrl_reg};
      cnd_pkg::A_NODE: rd_mux = {25'h0, node_reg};
      cnd_pkg::A_POP_LO: rd_mux = {16'h0, pop_reg[15:0]};
      cnd_pkg::A_POP_HI: rd_mux = {16'h0, pop_reg[31:16]};
      cnd_pkg::A_SDO_TMO: rd_mux = {16'h0, sdo_tmo_reg};
      cnd_pkg::A_HB: rd_mux = {16'h0, hb_reg};
      cnd_pkg::A_GUARD: rd_mux = {16'h0, guard_reg};
      cnd_pkg::A_LIFE: rd_mux = {24'h0, life_reg};
      cnd_pkg::A_ERRB: rd_mux = {30'h0, errb_reg};
      cnd_pkg::A_MAP: rd_mux = {30'h0, map_err_reg, map_ok_reg};
      cnd_pkg::A_STAT: rd_mux = {24'h0, guard_on, hb_on, q_cnt_reg, 1'b0, nmt_state_out};
      cnd_pkg::A_INW: rd_mux = {16'h0, inw_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = s_axi_araddr_in <= cnd_pkg::A_INW && s_axi_araddr_in[1:0] == 2'b00;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= 2'b00;
      s_axi_rdata_out <= 32'h0000_0000;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      ctrl_reg <= 3'b000;
      node_reg <= cnd_pkg::NODE_RST;
      pop_reg <= 32'h0000_0000;
      sdo_tmo_reg <= cnd_pkg::SDO_TMO_RST;
      hb_reg <= 16'h0000;
      guard_reg <= 16'h0000;
      life_reg <= 8'h00;
      errb_reg <= 2'b00;
      map_ok_reg <= 1'b0;
      map_err_reg <= 1'b0;
    end else if (clk_en_in) begin
      s_axi_awready_out <= !aw_got_reg && !aw_take && !s_axi_bvalid_out;
      s_axi_wready_out <= !w_got_reg && !w_take && !s_axi_bvalid_out;
      if (aw_take) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      // hardware self-clear loses to a software write in the same cycle
      if (pop_done) begin
        ctrl_reg[cnd_pkg::B_POPUP] <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= wd[2:0];
      end
      // out-of-range addresses are refused and keep the old value
      if (wr_go && wa == cnd_pkg::A_NODE && ws[0] && wd[6:0] != 7'h00) begin
        node_reg <= wd[6:0];
      end
      if (wr_go && wa == cnd_pkg::A_POP_LO && (&ws[1:0])) pop_reg[15:0] <= wd[15:0];
      if (wr_go && wa == cnd_pkg::A_POP_HI && (&ws[1:0])) pop_reg[31:16] <= wd[15:0];
      if (wr_go && wa == cnd_pkg::A_SDO_TMO && (&ws[1:0])) sdo_tmo_reg <= wd[15:0];
      if (wr_go && wa == cnd_pkg::A_HB && (&ws[1:0])) hb_reg <= wd[15:0];
      if (wr_go && wa == cnd_pkg::A_GUARD && (&ws[1:0])) guard_reg <= wd[15:0];
      if (wr_go && wa == cnd_pkg::A_LIFE && ws[0]) life_reg <= wd[7:0];
      if (wr_go && wa == cnd_pkg::A_ERRB && ws[0] && wd[1:0] != 2'b11) errb_reg <= wd[1:0];
      if (wr_map) begin
        map_ok_reg <= map_good;
        map_err_reg <= map_err_reg | !map_good;
      end
      if (s_axi_arready_out && s_axi_arvalid_in) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_mux;
        s_axi_rresp_out <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end else if (!s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // parameter store, sdo answers next cycle
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sdo_rsp_out <= '0;
    end else if (clk_en_in) begin
      sdo_rsp_out.valid <= sdo_req_in.valid;
      sdo_rsp_out.abort <= sdo_req_in.valid && !s_ok;
      sdo_rsp_out.data <= s_sub0 ? {22'h0, s_cnt} : {p_hi, p_lo};
      if (s_wr && s_inr) begin
        par_reg[s_pn[8:0]] <= w_lo;
        if (s_rw && sdo_req_in.len > 3'd2 && s_nx) begin
          par_reg[s_pn1[8:0]] <= sdo_req_in.data[31:16];
        end
      end
    end
  end

  // emergency queue and frame
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      q_rd_reg <= 2'd0;
      q_wr_reg <= 2'd0;
      q_cnt_reg <= 3'd0;
      alarm_prev_reg <= 8'h00;
      pop_pend_reg <= 1'b0;
      emcy_pop_reg <= 1'b0;
      emcy_valid_out <= 1'b0;
      emcy_frame_out <= '0;
    end else if (clk_en_in) begin
      // a full queue leaves the change unseen so it is retried
      if (alarm_push || (alarm_chg && ctrl_reg[cnd_pkg::B_SUPP])) begin
        alarm_prev_reg <= alarm_status_param_in;
      end
      if (q_push) begin
        q_reg[q_wr_reg] <= new_e;
        q_wr_reg <= q_wr_reg + 2'd1;
      end
      if (pop_push) pop_pend_reg <= 1'b1;
      if (pop_done) pop_pend_reg <= 1'b0;
      q_cnt_reg <= q_cnt_reg + 3'(q_push) - 3'(load);
      if (load) begin
        q_rd_reg <= q_rd_reg + 2'd1;
        emcy_valid_out <= 1'b1;
        emcy_pop_reg <= head.popup;
        emcy_frame_out.id <= {cnd_pkg::EMCY_FUNC, node_reg};
        emcy_frame_out.data <= {head.data[31:24], head.data[23:16], head.data[15:8],
                                head.data[7:0], 1'b0, node_reg, cnd_pkg::EMCY_ERRREG,
                                head.code};
      end else if (sent) begin
        emcy_valid_out <= 1'b0;
        emcy_pop_reg <= 1'b0;
      end
    end
  end

  // timebase, nmt, guarding, heartbeat, pdo
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_half_reg <= 1'b0;
      nmt_state_out <= cnd_pkg::CND_BOOT;
      nmt_pend_reg <= 1'b0;
      nmt_cs_reg <= 8'h00;
      life_cnt_reg <= 24'h00_0000;
      hb_cnt_reg <= 16'h0000;
      sdo_cnt_reg <= 16'h0000;
      bus_off_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
      sdo_timeout_out <= 1'b0;
      hb_send_out <= 1'b0;
      pdo12_service_out <= 1'b0;
      pdo4_tx_out <= 1'b0;
      rtr_accept_out <= 1'b0;
      inw_reg <= 16'h0000;
    end else if (clk_en_in) begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'd1;
      if (tick) tick_half_reg <= !tick_half_reg;
      pdo12_service_out <= tick && tick_half_reg && oper;
      pdo4_tx_out <= sync_in && oper;
      rtr_accept_out <= rtr_valid_in && oper && rtr_chan_in != 2'd3;
      inw_reg <= {aux_analog_in, digital_inputs_in[4], drive_enable_in,
                  digital_inputs_in[3:0]};
      // commands arriving faster than one per tick overwrite the pending one
      if (tick) nmt_pend_reg <= 1'b0;
      if (nmt_mine) begin
        nmt_pend_reg <= 1'b1;
        nmt_cs_reg <= nmt_cmd_in;
      end
      nmt_state_out <= nmt_next;
      bus_off_prev_reg <= bus_off_in;
      sync_prev_reg <= sync_missing_in;
      if (guard_rx_in || !guard_on || guard_miss) begin
        life_cnt_reg <= 24'h00_0000;
      end else if (tick) begin
        life_cnt_reg <= life_cnt_reg + 24'd1;
      end
      hb_send_out <= 1'b0;
      if (!hb_on) begin
        hb_cnt_reg <= 16'h0000;
      end else if (tick) begin
        hb_cnt_reg <= hb_cnt_reg + 16'd1;
        if (hb_cnt_reg + 16'd1 >= hb_reg) begin
          hb_cnt_reg <= 16'h0000;
          hb_send_out <= 1'b1;
        end
      end
      sdo_timeout_out <= 1'b0;
      if (!sdo_busy_in || sdo_req_in.valid) begin
        sdo_cnt_reg <= 16'h0000;
      end else if (tick) begin
        sdo_cnt_reg <= sdo_cnt_reg + 16'd1;
        if (sdo_cnt_reg + 16'd1 == sdo_tmo_reg) sdo_timeout_out <= 1'b1;
      end
    end
  end
endmodule // cnd_node_services
`default_nettype wire

// [shared/cnd_pkg.sv]
`default_nettype none
package cnd_pkg;
  // timing
  localparam int unsigned CLK_PS = 4000;
  localparam int unsigned TICK_PS = 1024000000;
  localparam int unsigned TICK_CYC = TICK_PS / CLK_PS;
  // parameter store
  localparam int unsigned PAR_COUNT = 512;
  localparam logic [8:0] HI_BASE = 9'h0FF;
  localparam logic [15:0] SDO_TMO_RST = 16'h1388;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_NODE = 8'h04;
  localparam logic [7:0] A_POP_LO = 8'h08;
  localparam logic [7:0] A_POP_HI = 8'h0C;
  localparam logic [7:0] A_SDO_TMO = 8'h10;
  localparam logic [7:0] A_HB = 8'h14;
  localparam logic [7:0] A_GUARD = 8'h18;
  localparam logic [7:0] A_LIFE = 8'h1C;
  localparam logic [7:0] A_ERRB = 8'h20;
  localparam logic [7:0] A_MAP = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  localparam logic [7:0] A_INW = 8'h2C;
  // control bits
  localparam int unsigned B_SUPP = 0;
  localparam int unsigned B_SYNCCHK = 1;
  localparam int unsigned B_POPUP = 2;
  localparam logic [6:0] NODE_RST = 7'h01;
  // frame constants
  localparam logic [3:0] EMCY_FUNC = 4'h1;
  localparam logic [7:0] EMCY_ERRREG = 8'h01;
  localparam logic [15:0] POPUP_CODE = 16'hFF09;
  localparam int unsigned QDEPTH = 4;
  // nmt command specifiers
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RSTN = 8'h81;
  localparam logic [7:0] NMT_RSTC = 8'h82;
  typedef enum logic [1:0] {
    CND_BOOT = 2'b00, CND_PREOP = 2'b01, CND_OPER = 2'b10, CND_STOP = 2'b11
  } cnd_nmt_t;
  typedef struct packed {
    logic valid; logic write; logic [15:0] index; logic [7:0] sub;
    logic [2:0] len; logic [31:0] data;
  } cnd_sdo_req_t;
  typedef struct packed {
    logic valid; logic abort; logic [31:0] data;
  } cnd_sdo_rsp_t;
  typedef struct packed {
    logic [10:0] id; logic [63:0] data;
  } cnd_frame_t;
  typedef struct packed {
    logic popup; logic [15:0] code; logic [31:0] data;
  } cnd_emcy_t;
endpackage
`default_nettype wire

// [test/cnd_node_services_asserts.sv]
`default_nettype none
module cnd_node_services_asserts (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  // watched traffic
  input wire cnd_pkg::cnd_sdo_req_t sdo_req_in,
  input wire cnd_pkg::cnd_sdo_rsp_t sdo_rsp_out,
  input wire logic sync_in,
  input wire logic rtr_valid_in,
  input wire logic [1:0] rtr_chan_in,
  input wire logic rtr_accept_out,
  input wire logic pdo4_tx_out,
  input wire cnd_pkg::cnd_nmt_t nmt_state_out,
  input wire logic emcy_valid_out,
  input wire logic emcy_ready_in,
  input wire cnd_pkg::cnd_frame_t emcy_frame_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  AST_EMCY_FUNC: assert property (emcy_valid_out |-> emcy_frame_out.id[10:7] == 4'h1)
    else $error("emergency function bits wrong");
  AST_EMCY_NODE: assert property (emcy_valid_out |-> emcy_frame_out.id[6:0] != 7'h00 &&
    emcy_frame_out.data[31:24] == {1'b0, emcy_frame_out.id[6:0]}) else $error("node byte wrong");
  AST_ERR_REG: assert property (emcy_valid_out |-> emcy_frame_out.data[23:16] == 8'h01)
    else $error("error register byte wrong");
  AST_EMCY_HOLD: assert property (emcy_valid_out && !emcy_ready_in |=>
    emcy_valid_out && $stable(emcy_frame_out)) else $error("pending frame dropped");
  AST_SDO_ANSWER: assert property (clk_en_in && sdo_req_in.valid |=> sdo_rsp_out.valid)
    else $error("no sdo answer");
  AST_SUB0_RO: assert property (clk_en_in && sdo_req_in.valid && sdo_req_in.write &&
    sdo_req_in.sub == 8'h00 |=> sdo_rsp_out.abort) else $error("count entry written");
  AST_PDO4_SYNC: assert property (clk_en_in && sync_in &&
    nmt_state_out == cnd_pkg::CND_OPER |=> pdo4_tx_out) else $error("no pdo4 after sync");
  AST_PDO4_RTR: assert property (clk_en_in && rtr_valid_in && rtr_chan_in == 2'h3 |=>
    !rtr_accept_out) else $error("pdo4 remote request accepted");
endmodule // cnd_node_services_asserts
bind cnd_node_services cnd_node_services_asserts cnd_node_services_asserts_inst (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
  .sdo_req_in(sdo_req_in), .sdo_rsp_out(sdo_rsp_out), .sync_in(sync_in),
  .rtr_valid_in(rtr_valid_in), .rtr_chan_in(rtr_chan_in), .rtr_accept_out(rtr_accept_out),
  .pdo4_tx_out(pdo4_tx_out), .nmt_state_out(nmt_state_out), .emcy_valid_out(emcy_valid_out),
  .emcy_ready_in(emcy_ready_in), .emcy_frame_out(emcy_frame_out));
`default_nettype wire

// [test/cnd_can_master.sv]
`default_nettype none
module cnd_can_master (
  input wire logic core_clk_in,
  input wire logic [1:0] mode_in,
  output logic emcy_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 0 prompt, 1 one slot in three, 2 busy bus holds every frame back
  logic [1:0] slot_reg = 2'h0;
  always @(posedge core_clk_in) slot_reg <= (slot_reg == 2'h2) ? 2'h0 : slot_reg + 2'h1;
  assign emcy_ready_out = (mode_in == 2'h0) || (mode_in == 2'h1 && slot_reg == 2'h0);
endmodule // cnd_can_master
`default_nettype wire

// [test/cnd_node_services_tb.sv]
`default_nettype none
module cnd_node_services_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 16;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic nmtv = 1'b0, bus_off = 1'b0, sync = 1'b0, rtrv = 1'b0, en = 1'b0, awr, wr, bv, arr, rv;
  logic acc, rdy, ev;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, alarm = 8'h00, nmtc = 8'h00;
  logic [31:0] wdata = 32'h0, rd, d;
  logic [4:0] din = 5'h00;
  logic [9:0] ana = 10'h000;
  logic [1:0] rtrc = 2'h0, mode = 2'h0, br, rr;
  logic [6:0] node = 7'h01;
  logic [15:0] plo, phi;
  cnd_pkg::cnd_sdo_req_t req = '0;
  cnd_pkg::cnd_sdo_rsp_t rsp;
  cnd_pkg::cnd_frame_t fr;
  cnd_pkg::cnd_nmt_t st;
  logic [33:0] rq[$], sq[$];
  cnd_pkg::cnd_frame_t eq[$];
  logic [7:0] al [6] = '{8'h01, 8'h02, 8'h03, 8'h0B, 8'h15, 8'h1C};
  logic [15:0] ec [6] = '{16'h3210, 16'h3220, 16'h2340, 16'h6310, 16'h5112, 16'h7320};
  int mismatches = 0, tests_run = 0, cyc = 0;
  cnd_node_services #(.TICK_CYCLES(TK)) cnd_node_services_inst (
    .core_clk_in(clk), .resetn_in(rstn), .clk_en_in(1'b1), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rready), .alarm_status_param_in(alarm), .digital_inputs_in(din),
    .drive_enable_in(en), .aux_analog_in(ana), .sdo_req_in(req), .sdo_rsp_out(rsp),
    .sdo_busy_in(1'b0), .sdo_timeout_out(), .nmt_valid_in(nmtv), .nmt_cmd_in(nmtc),
    .nmt_node_in(node), .guard_rx_in(1'b0), .bus_off_in(bus_off), .sync_missing_in(1'b0),
    .sync_in(sync), .rtr_valid_in(rtrv), .rtr_chan_in(rtrc), .rtr_accept_out(acc),
    .pdo12_service_out(), .pdo4_tx_out(), .hb_send_out(), .nmt_state_out(st),
    .emcy_valid_out(ev), .emcy_ready_in(rdy), .emcy_frame_out(fr));
  cnd_can_master cnd_can_master_inst (.core_clk_in(clk), .mode_in(mode), .emcy_ready_out(rdy));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [74:0] seen, input logic [74:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    rq.push_back(e);
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
  endtask
  // e holds {check data, abort, data}
  task automatic sdo(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] v, input logic [33:0] e);
    @(posedge clk);
    req <= {1'b1, w, ix, sb, 3'h4, v};
    sq.push_back(e);
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic cnd_pkg::cnd_frame_t fx(input logic [15:0] c, input logic [31:0] w);
    return {4'h1, node, w, 1'b0, node, 8'h01, c};
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv && rready) chk({rr, rd}, rq.pop_front());
    if (ev && rdy) chk(fr, eq.pop_front());
    if (rsp.valid) begin
      chk({rsp.abort, sq[0][33] ? rsp.data : 32'h0}, sq[0][32:0]);
      void'(sq.pop_front());
    end
    if (cyc == 5000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'hB4769A8C));
    node = 7'($urandom_range(127, 1));
    din = 5'($urandom());
    ana = 10'($urandom());
    en = 1'($urandom());
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    axr(cnd_pkg::A_SDO_TMO, {2'h0, 32'h00001388});
    axr(8'h40, {2'h2, 32'h0});
    axw(cnd_pkg::A_NODE, {25'h0, node});
    axr(cnd_pkg::A_INW, {18'h0, ana, din[4], en, din[3:0]});
    mode <= 2'h2;
    for (int i = 0; i < 6; i++) begin
      if (i == 3) mode <= 2'h1;
      alarm <= al[i];
      eq.push_back(fx(ec[i], {24'h0, al[i]}));
      repeat (3) @(posedge clk);
    end
    mode <= 2'h0;
    repeat (30) @(posedge clk);
    axw(cnd_pkg::A_CTRL, 32'h1);
    alarm <= 8'h05;
    repeat (10) @(posedge clk);
    axw(cnd_pkg::A_CTRL, 32'h0);
    alarm <= 8'h00;
    eq.push_back(fx(16'h0000, 32'h0));
    plo = 16'($urandom());
    phi = 16'($urandom());
    axw(cnd_pkg::A_POP_LO, {16'h0, plo});
    axw(cnd_pkg::A_POP_HI, {16'h0, phi});
    eq.push_back(fx(16'hFF09, {phi, plo}));
    axw(cnd_pkg::A_CTRL, 32'h4);
    repeat (10) @(posedge clk);
    axr(cnd_pkg::A_CTRL, 34'h0);
    axw(cnd_pkg::A_MAP, 32'h6040_1002);
    axr(cnd_pkg::A_MAP, 34'h1);
    axw(cnd_pkg::A_MAP, 32'h6063_2002);
    axr(cnd_pkg::A_MAP, 34'h2);
    d = $urandom();
    sdo(1'b1, 16'h2000, 8'h51, d, 34'h0);
    sdo(1'b0, 16'h2000, 8'h51, 32'h0, {2'h2, d});
    sdo(1'b1, 16'h2000, 8'h29, 32'h123400F0, 34'h0);
    sdo(1'b1, 16'h2002, 8'h29, 32'h00000003, 34'h0);
    sdo(1'b1, 16'h2004, 8'h29, 32'h00000030, 34'h0);
    sdo(1'b0, 16'h2000, 8'h29, 32'h0, {2'h2, 32'h123400C3});
    sdo(1'b0, 16'h2000, 8'h00, 32'h0, {2'h2, 32'h000000FF});
    sdo(1'b1, 16'h2000, 8'h00, 32'h0, {2'h1, 32'h0});
    sdo(1'b1, 16'h2006, 8'h01, 32'h0, {2'h1, 32'h0});
    nmtc <= cnd_pkg::NMT_START;
    nmtv <= 1'b1;
    @(posedge clk);
    nmtv <= 1'b0;
    repeat (2 * TK + 2) @(posedge clk);
    chk(st, cnd_pkg::CND_OPER);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        rtrc <= 2'(c);
        rtrv <= 1'b1;
        @(posedge clk);
        rtrv <= 1'b0;
        @(posedge clk);
        chk(acc, c != 3);
      end
    end
    axw(cnd_pkg::A_ERRB, 32'h2);
    axw(cnd_pkg::A_GUARD, 32'hC8);
    axw(cnd_pkg::A_LIFE, 32'h1);
    bus_off <= 1'b1;
    repeat (2 * TK) @(posedge clk);
    chk(st, cnd_pkg::CND_STOP);
    chk(eq.size(), 0);
    axw(cnd_pkg::A_HB, 32'h5);
    axr(cnd_pkg::A_STAT, 34'h43);
    final_report();
  end
endmodule // cnd_node_services_tb
`default_nettype wire
